// file: scm_clock_ctrl.sv
// System clock generation and NORMAL/IDLE/SLEEP mode control.
// Assumes all inputs come from logic on core_clk_i; clocks leave as enables.
//
// Function
// - The RC oscillator runs at 32, 64 or 128 kHz fixed by a build parameter.
// - The high-speed clock comes from the internal RC oscillator alone.
// - One system clock feeds CPU and peripherals, undivided or divided by the select field.
// - In NORMAL the system clock is the high-speed clock over 1 to 64 with the substitute on.
// - The substitute clock is derived from the oscillator at a fixed 32 kHz.
// - Four modes exist: NORMAL with CPU running, IDLE, SLEEP and WAKE with the CPU stopped.
// - Halt with keep-oscillator set enters IDLE: CPU clock stops, the others keep running.
// - Halt with keep-oscillator clear enters SLEEP: CPU, system and high-speed clocks stop.
// - In SLEEP the substitute clock runs only while the watchdog is enabled.
// - In IDLE the oscillator keeps running for peripherals but is gated from the CPU.
// - Halting during a nonvolatile access makes that access fail.
// - Select 000 and 111 are undivided, 001 to 110 divide by 2 to 64.
// - A divider change completes within four system periods plus one boundary.
// - Entering IDLE or SLEEP sets the power-down flag and clears the timeout flag, unless a watchdog timeout arrives in the same cycle.
`timescale 1ns/1ps
`include "scm_consts.svh"
module scm_clock_ctrl
    import scm_pkg::*;
#(
    parameter int IRC_KHZ       = `SCM_IRC_KHZ_DEF,
    parameter int STABLE_CYCLES = `SCM_OSC_STABLE_US * (`SCM_CORE_CLK_HZ / 1000000)
) (
    input  wire logic                      core_clk_i,
    input  wire logic                      rst_i,
    input  wire logic                      clk_en_i,
    input  wire logic [`SCM_DIV_SEL_W-1:0] sys_clk_divider_select_i,
    input  wire logic                      idle_osc_keep_enable_i,
    input  wire logic                      halt_i,
    input  wire logic                      wake_i,
    input  wire logic                      wdt_enable_i,
    input  wire logic                      wdt_timeout_i,
    input  wire logic                      wdt_clear_i,
    input  wire logic                      nv_busy_i,
    output scm_ticks_t                     ticks_o,
    output scm_mode_t                      mode_o,
    output scm_flags_t                     flags_o,
    output logic                           div_switch_busy_o,
    output logic                           nv_abort_o
);
    // ----------------------------------------------------------------
    // Derived constants
    // ----------------------------------------------------------------
    localparam int IRC_CYC   = `SCM_CORE_CLK_HZ / (IRC_KHZ * 1000);
    localparam int SUB_RATIO = IRC_KHZ * 1000 / `SCM_SUB_CLK_HZ;
    localparam int IRC_W     = $clog2(IRC_CYC + 1);
    localparam int STB_W     = $clog2(STABLE_CYCLES + 1);

    initial begin
        if (IRC_KHZ != 32 && IRC_KHZ != 64 && IRC_KHZ != 128)
            $error("scm_clock_ctrl: IRC_KHZ must be 32, 64 or 128");
        if (STABLE_CYCLES < 1) $error("scm_clock_ctrl: STABLE_CYCLES below one");
    end

    function automatic logic [2:0] sel_shift(input logic [`SCM_DIV_SEL_W-1:0] sel);
        sel_shift = (sel == `SCM_DIV_SEL_UNDIV) ? 3'h0 : sel;
    endfunction : sel_shift

    function automatic logic [`SCM_DIV_CNT_W-1:0] sel_last(
        input logic [`SCM_DIV_SEL_W-1:0] sel);
        logic [6:0] ratio;
        ratio    = 7'h01 << sel_shift(sel);
        sel_last = 6'(ratio - 7'h01);
    endfunction : sel_last

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    scm_mode_t                   state_q;
    logic [IRC_W-1:0]            irc_cnt_q;
    logic [`SCM_DIV_SEL_W-1:0]   active_sel_q;
    logic [2:0]                  sw_cnt_q;
    logic [STB_W-1:0]            stb_cnt_q;
    logic                        pdf_q;
    logic                        to_q;
    logic                        osc_on;
    logic                        irc_tick;
    logic                        hs_tick;
    logic                        sys_tick;
    logic                        sub_tick;
    logic                        cpu_tick;
    logic                        pending;
    logic                        load_sel;
    logic                        halt_ok;
    logic [`SCM_DIV_CNT_W-1:0]   div_cnt;
    logic [1:0]                  sub_cnt;

    // ----------------------------------------------------------------
    // Oscillator and clock enables
    // ----------------------------------------------------------------
    assign osc_on   = !(state_q == SCM_SLEEP && !wdt_enable_i);
    assign irc_tick = osc_on && (irc_cnt_q == IRC_W'(IRC_CYC - 1));
    assign hs_tick  = irc_tick && (state_q != SCM_SLEEP);
    assign cpu_tick = sys_tick && (state_q == SCM_NORMAL);
    assign halt_ok  = halt_i && (state_q == SCM_NORMAL);

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            irc_cnt_q <= '0;
        end else if (clk_en_i) begin
            if (!osc_on || irc_tick) begin
                irc_cnt_q <= '0;
            end else begin
                irc_cnt_q <= irc_cnt_q + IRC_W'(1);
            end
        end
    end

    scm_tick_div #(.W(`SCM_DIV_CNT_W)) u_sys_div (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .clk_en_i   (clk_en_i),
        .tick_i     (hs_tick),
        .restart_i  (load_sel),
        .last_i     (sel_last(active_sel_q)),
        .tick_o     (sys_tick),
        .count_o    (div_cnt)
    );

    scm_tick_div #(.W(2)) u_sub_div (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .clk_en_i   (clk_en_i),
        .tick_i     (irc_tick),
        .restart_i  (1'b0),
        .last_i     (2'(SUB_RATIO - 1)),
        .tick_o     (sub_tick),
        .count_o    (sub_cnt)
    );

    // ----------------------------------------------------------------
    // Divider switching
    // ----------------------------------------------------------------
    assign pending  = (sys_clk_divider_select_i != active_sel_q);
    assign load_sel = pending && sys_tick &&
                      (sw_cnt_q == 3'(`SCM_SWITCH_SYS_TICKS));

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            active_sel_q <= `SCM_DIV_SEL_RST;
            sw_cnt_q     <= 3'h0;
        end else if (clk_en_i) begin
            if (!pending || load_sel) begin
                sw_cnt_q <= 3'h0;
            end else if (sys_tick && sw_cnt_q != 3'(`SCM_SWITCH_SYS_TICKS)) begin
                sw_cnt_q <= sw_cnt_q + 3'h1;
            end
            if (load_sel) begin
                active_sel_q <= sys_clk_divider_select_i;
            end
        end
    end

    // ----------------------------------------------------------------
    // Mode control
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q   <= SCM_NORMAL;
            stb_cnt_q <= '0;
        end else if (clk_en_i) begin
            unique case (state_q)
                SCM_NORMAL: begin
                    if (halt_ok) begin
                        state_q <= idle_osc_keep_enable_i ? SCM_IDLE : SCM_SLEEP;
                    end
                end
                SCM_IDLE: begin
                    if (wake_i) begin
                        state_q <= SCM_NORMAL;
                    end
                end
                SCM_SLEEP: begin
                    stb_cnt_q <= '0;
                    if (wake_i) begin
                        state_q <= SCM_WAKE;
                    end
                end
                SCM_WAKE: begin
                    if (stb_cnt_q == STB_W'(STABLE_CYCLES - 1)) begin
                        state_q <= SCM_NORMAL;
                    end else begin
                        stb_cnt_q <= stb_cnt_q + STB_W'(1);
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pdf_q <= 1'b0;
            to_q  <= 1'b0;
        end else if (clk_en_i) begin
            if (halt_ok) begin
                pdf_q <= 1'b1;
            end else if (wdt_clear_i) begin
                pdf_q <= 1'b0;
            end
            if (wdt_timeout_i) begin
                to_q <= 1'b1;
            end else if (halt_ok) begin
                to_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Registered outputs
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ticks_o           <= '0;
            mode_o            <= SCM_NORMAL;
            flags_o           <= '0;
            div_switch_busy_o <= 1'b0;
            nv_abort_o        <= 1'b0;
        end else if (clk_en_i) begin
            ticks_o           <= '{cpu: cpu_tick, sys: sys_tick, hs: hs_tick, sub: sub_tick};
            mode_o            <= state_q;
            flags_o           <= '{power_down_flag: pdf_q, watchdog_timeout_flag: to_q};
            div_switch_busy_o <= pending && !load_sel;
            nv_abort_o        <= halt_ok && nv_busy_i;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    logic [8:0] wait_hs_q;
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wait_hs_q <= '0;
        end else if (clk_en_i) begin
            wait_hs_q <= (!pending || load_sel) ? 9'h000 :
                         (hs_tick ? wait_hs_q + 9'h001 : wait_hs_q);
        end
    end

    property p_idle_cpu_off;
        @(posedge core_clk_i) disable iff (rst_i)
        state_q == SCM_IDLE |-> !cpu_tick && (irc_tick == hs_tick);
    endproperty
    a_idle_cpu_off: assert property (p_idle_cpu_off) else $error("IDLE clocks wrong");
    property p_sleep_off;
        @(posedge core_clk_i) disable iff (rst_i)
        state_q == SCM_SLEEP |-> !sys_tick && !hs_tick && !cpu_tick;
    endproperty
    a_sleep_off: assert property (p_sleep_off) else $error("clock runs in SLEEP");
    property p_sleep_sub;
        @(posedge core_clk_i) disable iff (rst_i)
        clk_en_i && state_q == SCM_SLEEP && !wdt_enable_i |-> !sub_tick ##1 (irc_cnt_q == '0);
    endproperty
    a_sleep_sub: assert property (p_sleep_sub) else $error("substitute runs");
    property p_enter_flags;
        @(posedge core_clk_i) disable iff (rst_i)
        clk_en_i && halt_ok && !wdt_timeout_i |=> pdf_q && !to_q && state_q != SCM_NORMAL;
    endproperty
    a_enter_flags: assert property (p_enter_flags) else $error("entry flags wrong");
    property p_undiv;
        @(posedge core_clk_i) disable iff (rst_i)
        hs_tick && sel_shift(active_sel_q) == 3'h0 |-> sys_tick;
    endproperty
    a_undiv: assert property (p_undiv) else $error("undivided select divides");
    property p_switch_bound;
        @(posedge core_clk_i) disable iff (rst_i)
        wait_hs_q <= 9'h140;
    endproperty
    a_switch_bound: assert property (p_switch_bound) else $error("switch too slow");
    property p_load_on_edge;
        @(posedge core_clk_i) disable iff (rst_i)
        load_sel |-> sys_tick && div_cnt == sel_last(active_sel_q);
    endproperty
    a_load_on_edge: assert property (p_load_on_edge) else $error("switch mid-period");
    property p_wake_stable;
        @(posedge core_clk_i) disable iff (rst_i)
        clk_en_i && state_q == SCM_SLEEP && wake_i |=> state_q == SCM_WAKE && !cpu_tick;
    endproperty
    a_wake_stable: assert property (p_wake_stable) else $error("wake skipped delay");
    property p_nv_abort;
        @(posedge core_clk_i) disable iff (rst_i)
        clk_en_i && halt_ok && nv_busy_i |=> nv_abort_o;
    endproperty
    a_nv_abort: assert property (p_nv_abort) else $error("nv abort missing");
    property p_sub_from_irc;
        @(posedge core_clk_i) disable iff (rst_i)
        sub_tick |-> irc_tick && sub_cnt == 2'(SUB_RATIO - 1);
    endproperty
    a_sub_from_irc: assert property (p_sub_from_irc) else $error("substitute rate");

    c_idle:   cover property (@(posedge core_clk_i) state_q == SCM_IDLE);
    c_sleep:  cover property (@(posedge core_clk_i) state_q == SCM_SLEEP && wdt_enable_i);
    c_wake:   cover property (@(posedge core_clk_i) state_q == SCM_WAKE ##1 state_q == SCM_NORMAL);
    c_switch: cover property (@(posedge core_clk_i) load_sel);
endmodule : scm_clock_ctrl

// file: scm_consts.svh
// Constants for the system clock and power mode controller.
// Assumes a 40 MHz core clock; all clocks are modelled as enable pulses.
`ifndef SCM_CONSTS_SVH
`define SCM_CONSTS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SCM_CORE_CLK_HZ      40000000
`define SCM_SUB_CLK_HZ       32000
`define SCM_IRC_KHZ_DEF      32
`define SCM_OSC_STABLE_US    64
`define SCM_SWITCH_SYS_TICKS 4

// ----------------------------------------------------------------
// Divider select and reset values
// ----------------------------------------------------------------
`define SCM_DIV_SEL_W        3
`define SCM_DIV_SEL_RST      3'h0
`define SCM_DIV_SEL_UNDIV    3'h7
`define SCM_DIV_CNT_W        6

`endif

// file: scm_pkg.sv
// Types shared by the clock and power mode controller.
// Assumes scm_consts.svh is on the include path.
package scm_pkg;

    typedef enum logic [1:0] {
        SCM_NORMAL = 2'b00,
        SCM_IDLE   = 2'b01,
        SCM_SLEEP  = 2'b10,
        SCM_WAKE   = 2'b11
    } scm_mode_t;

    typedef struct packed {
        logic cpu;
        logic sys;
        logic hs;
        logic sub;
    } scm_ticks_t;

    typedef struct packed {
        logic power_down_flag;
        logic watchdog_timeout_flag;
    } scm_flags_t;

endpackage : scm_pkg

// file: scm_tick_div.sv
// Divides an enable pulse stream by a programmable ratio.
// Assumes tick_i is a single-cycle pulse on core_clk_i.
`timescale 1ns/1ps
module scm_tick_div #(
    parameter int W = 6
) (
    input  wire logic         core_clk_i,
    input  wire logic         rst_i,
    input  wire logic         clk_en_i,
    input  wire logic         tick_i,
    input  wire logic         restart_i,
    input  wire logic [W-1:0] last_i,
    output logic              tick_o,
    output logic [W-1:0]      count_o
);
    initial begin
        if (W < 1) $error("scm_tick_div: W must be at least 1");
    end

    assign tick_o  = tick_i && (count_o == last_i);

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            count_o <= '0;
        end else if (clk_en_i) begin
            if (restart_i || tick_o) begin
                count_o <= '0;
            end else if (tick_i) begin
                count_o <= count_o + W'(1);
            end
        end
    end
endmodule : scm_tick_div

// file: scm_clock_ctrl_tb_top.sv
// Self-checking bench for the clock and power mode controller.
// Assumes scm_pkg and scm_consts.svh; the design is built at 128 kHz.
`timescale 1ns/1ps
module scm_clock_ctrl_tb_top;
import scm_pkg::*;
// ----------------------------------------------------------------
// Setup
// ----------------------------------------------------------------
localparam int IRC_CYC = 312; // Core cycles per oscillator tick
localparam int SUB_CYC = IRC_CYC * 4;
localparam int STABLE  = 8;
logic       core_clk_i;
logic       rst_i;
logic       clk_en_i;
logic [2:0] sel_i;
logic       keep_i;
logic       halt_i;
logic       wake_i;
logic       wdt_en_i;
logic       wdt_to_i;
logic       wdt_clr_i;
logic       nv_busy_i;
scm_ticks_t ticks_o;
scm_mode_t  mode_o;
scm_flags_t flags_o;
logic       busy_o;
logic       abort_o;
int         fails;
int         samples_checked;
int         aborts;
int         c_cpu;
int         c_sys;
int         c_hs;
int         c_sub;
int         n;

scm_clock_ctrl #(.IRC_KHZ(128), .STABLE_CYCLES(STABLE)) scm_clock_ctrl_i (
    .core_clk_i               (core_clk_i),
    .rst_i                    (rst_i),
    .clk_en_i                 (clk_en_i),
    .sys_clk_divider_select_i (sel_i),
    .idle_osc_keep_enable_i   (keep_i),
    .halt_i                   (halt_i),
    .wake_i                   (wake_i),
    .wdt_enable_i             (wdt_en_i),
    .wdt_timeout_i            (wdt_to_i),
    .wdt_clear_i              (wdt_clr_i),
    .nv_busy_i                (nv_busy_i),
    .ticks_o                  (ticks_o),
    .mode_o                   (mode_o),
    .flags_o                  (flags_o),
    .div_switch_busy_o        (busy_o),
    .nv_abort_o               (abort_o)
);

initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
end

always @(negedge core_clk_i) begin
    if (abort_o === 1'b1) aborts++;
end
// ----------------------------------------------------------------
// Tasks
// ----------------------------------------------------------------
task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
        fails++;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
endtask : chk

task automatic cyc(input int k);
    repeat (k) @(negedge core_clk_i);
endtask : cyc

task automatic count_ticks(input int k);
    c_cpu = 0;
    c_sys = 0;
    c_hs  = 0;
    c_sub = 0;
    repeat (k) begin
        @(negedge core_clk_i);
        c_cpu += (ticks_o.cpu === 1'b1);
        c_sys += (ticks_o.sys === 1'b1);
        c_hs  += (ticks_o.hs === 1'b1);
        c_sub += (ticks_o.sub === 1'b1);
    end
endtask : count_ticks

task automatic sys_period(output int p);
    p = 0;
    n = 0;
    while (ticks_o.sys !== 1'b1 && n < 30000) begin
        @(negedge core_clk_i);
        n++;
    end
    do begin
        @(negedge core_clk_i);
        p++;
    end while (ticks_o.sys !== 1'b1 && p < 30000);
endtask : sys_period

task automatic set_div(input logic [2:0] sel, input int ratio, input int old);
    int p;
    int lim;
    lim = 4 * IRC_CYC * old + (3 * IRC_CYC * old + IRC_CYC * ratio) / 2 + 3;
    @(negedge core_clk_i);
    sel_i = sel;
    cyc(2);
    n = 2;
    while (busy_o !== 1'b0 && n < 40000) begin
        cyc(1);
        n++;
    end
    chk(n <= lim, 1'b1);
    sys_period(p);
    chk(p, IRC_CYC * ratio);
endtask : set_div

task automatic do_halt(input logic keep, input logic wdt, input logic nvb);
    @(negedge core_clk_i);
    keep_i    = keep;
    wdt_en_i  = wdt;
    nv_busy_i = nvb;
    halt_i    = 1'b1;
    cyc(1);
    halt_i    = 1'b0;
    cyc(2);
    nv_busy_i = 1'b0;
endtask : do_halt

task automatic pulse_in(input int which);
    @(negedge core_clk_i);
    if (which == 0) wake_i = 1'b1;
    else if (which == 1) wdt_to_i = 1'b1;
    else wdt_clr_i = 1'b1;
    cyc(1);
    wake_i    = 1'b0;
    wdt_to_i  = 1'b0;
    wdt_clr_i = 1'b0;
    cyc(2);
endtask : pulse_in

task automatic test_done;
    $display("Checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
        $display("Simulation passed");
    else
        $display("Simulation failed");
    $finish;
endtask : test_done
// ----------------------------------------------------------------
// Tests
// ----------------------------------------------------------------
initial begin
    #(95000 * 25);
    fails++;
    test_done();
end

initial begin
    rst_i           = 1'b1;
    clk_en_i        = 1'b1;
    sel_i           = 3'h0;
    keep_i          = 1'b0;
    halt_i          = 1'b0;
    wake_i          = 1'b0;
    wdt_en_i        = 1'b1;
    wdt_to_i        = 1'b0;
    wdt_clr_i       = 1'b0;
    nv_busy_i       = 1'b0;
    fails           = 0;
    samples_checked = 0;
    aborts          = 0;
    repeat (16) @(posedge core_clk_i);
    @(negedge core_clk_i);
    rst_i = 1'b0;
    cyc(2);
    chk(mode_o, SCM_NORMAL);
    chk(flags_o, 2'h0);
    set_div(3'h7, 1, 1);
    set_div(3'h1, 2, 1);
    set_div(3'h2, 4, 2);
    set_div(3'h4, 16, 4);
    set_div(3'h1, 2, 16);
    count_ticks(2 * SUB_CYC);
    chk({c_cpu, c_sys}, {32'h4, 32'h4});
    chk({c_hs, c_sub}, {32'h8, 32'h2});
    do_halt(1'b1, 1'b1, 1'b0);
    chk(mode_o, SCM_IDLE);
    chk(flags_o, 2'h2);
    chk(aborts, 0);
    count_ticks(2 * SUB_CYC);
    chk({c_cpu, c_sys}, {32'h0, 32'h4});
    chk({c_hs, c_sub}, {32'h8, 32'h2});
    do_halt(1'b0, 1'b1, 1'b0);
    chk(mode_o, SCM_IDLE);
    pulse_in(0);
    chk(mode_o, SCM_NORMAL);
    count_ticks(2 * SUB_CYC);
    chk(c_cpu, 4);
    pulse_in(2);
    pulse_in(1);
    chk(flags_o, 2'h1);
    do_halt(1'b0, 1'b1, 1'b1);
    chk(mode_o, SCM_SLEEP);
    chk(flags_o, 2'h2);
    chk(aborts, 1);
    count_ticks(2 * SUB_CYC);
    chk({c_cpu, c_sys}, {32'h0, 32'h0});
    chk({c_hs, c_sub}, {32'h0, 32'h2});
    pulse_in(0);
    chk(mode_o, SCM_WAKE);
    n = 0;
    while (mode_o !== SCM_NORMAL && n < 100) begin
        cyc(1);
        n++;
    end
    chk(n <= STABLE + 2, 1'b1);
    sys_period(n);
    chk(n, IRC_CYC * 2);
    do_halt(1'b0, 1'b0, 1'b0);
    chk(mode_o, SCM_SLEEP);
    count_ticks(2 * SUB_CYC);
    chk({c_hs, c_sub}, {32'h0, 32'h0});
    pulse_in(0);
    cyc(STABLE + 4);
    chk(mode_o, SCM_NORMAL);
    clk_en_i = 1'b0;
    do_halt(1'b1, 1'b1, 1'b1);
    chk(mode_o, SCM_NORMAL);
    chk(aborts, 1);
    clk_en_i = 1'b1;
    test_done();
end

endmodule : scm_clock_ctrl_tb_top
